// [design/fcl_driver.sv]
// five-channel led chain driver: rz receive, forward, latch and pwm
// Operation
// [RL1] data arrives on one wire as return-to-zero pulses, decoded alone
// [RL2] after power-on reset the primary input starts receiving
// [RL3] first 40 bits after a frame reset go to the shadow latch
// [RL4] later bits are regenerated with clean timing on the cascade output
// [RL5] channel outputs keep old levels until a frame reset arrives
// [RL6] low longer than 280 us applies the captured 40 bits
// [RL7] when the long low ends, capture restarts from bit zero
// [RL8] each output is pwm with duty set by its own byte
// [RL9] pwm has 256 steps and repeats near 4 khz
// [RL10] channel turn-on points are staggered to spread supply ripple
// [RL11] receive and forward keep pace with 800 kbit/s
// [RL12] short high pulse (220..380 ns) decodes as zero
// [RL13] long high pulse (580 ns..1 us) decodes as one
// [RL14] bytes msb first in order red, green, blue, white1, white2
// [RL15] backup input takes over when the primary stays silent
// [RL16] all timing derives from the local clock, no external clock
module fcl_driver
   import fcl_pkg::*;
#(
   parameter int RESET_CYC = RESET_LOW_CYC,
   parameter int SILENT_CYC = RESET_LOW_CYC
) (
   input logic clock,
   input logic rst_b,
   input logic primary_serial_in,
   input logic backup_serial_in,
   output logic cascade_serial_out,
   output logic red_channel_out,
   output logic green_channel_out,
   output logic blue_channel_out,
   output logic white_one_channel_out,
   output logic white_two_channel_out
);
   // pin synchronisers; stages two and three are read by logic
   logic pri_m_q, pri_s_q, bak_m_q, bak_s_q;
   logic pri_p_q, bak_p_q;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pri_m_q <= 1'b0;
         pri_s_q <= 1'b0;
         bak_m_q <= 1'b0;
         bak_s_q <= 1'b0;
         pri_p_q <= 1'b0;
         bak_p_q <= 1'b0;
      end else begin
         pri_m_q <= primary_serial_in;
         pri_s_q <= pri_m_q;
         bak_m_q <= backup_serial_in;
         bak_s_q <= bak_m_q;
         pri_p_q <= pri_s_q;
         bak_p_q <= bak_s_q;
      end
   end

   // input selection: primary after reset, backup only after silence
   logic sel_bak_q, sel_bak_d;
   logic [RUN_W-1:0] idle_q, idle_d;
   logic pri_edge, bak_edge;

   assign pri_edge = pri_s_q ^ pri_p_q;
   assign bak_edge = bak_s_q & ~bak_p_q;

   always_comb begin
      sel_bak_d = sel_bak_q;
      idle_d = idle_q;
      if (pri_edge) begin
         idle_d = '0;
         sel_bak_d = 1'b0; // RL2
      end else begin
         if (idle_q != RUN_W'(SILENT_CYC)) begin
            idle_d = idle_q + 1'b1;
         end
         if (idle_q == RUN_W'(SILENT_CYC) && bak_edge) begin
            sel_bak_d = 1'b1; // RL15
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sel_bak_q <= 1'b0;
         idle_q <= '0;
      end else begin
         sel_bak_q <= sel_bak_d;
         idle_q <= idle_d;
      end
   end

   // rz decoder: measure each level's run length on the chosen line
   logic line, line_p;
   logic [RUN_W-1:0] run_q, run_d;
   logic bit_fall, bit_val, frame_rst;

   assign line = sel_bak_q ? bak_s_q : pri_s_q; // RL1
   assign line_p = sel_bak_q ? bak_p_q : pri_p_q;
   assign bit_fall = line_p & ~line;
   assign bit_val = (run_q >= RUN_W'(ONE_MIN_CYC)); // RL12 RL13
   assign frame_rst = ~line & ~line_p
      & (run_q == RUN_W'(RESET_CYC - 1)); // RL6

   always_comb begin
      if (line != line_p) begin
         run_d = RUN_W'(1);
      end else if (run_q != '1) begin
         run_d = run_q + 1'b1;
      end else begin
         run_d = run_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         run_q <= '0;
      end else begin
         run_q <= run_d;
      end
   end

   // capture: own 40 bits into the shadow, the rest into the buffer
   fcl_fifo_if #(.W(1)) fwd ();
   logic [FRAME_BITS-1:0] shadow_q, shadow_d;
   logic [NUM_CHAN-1:0][CHAN_BITS-1:0] duty_q, duty_d;
   logic [BITCNT_W-1:0] bitcnt_q, bitcnt_d;
   logic own_full, apply;

   assign own_full = (bitcnt_q == BITCNT_W'(FRAME_BITS));
   assign apply = frame_rst & own_full;
   assign fwd.wr_data = bit_val;
   assign fwd.wr_valid = bit_fall & own_full; // RL4

   always_comb begin
      shadow_d = shadow_q;
      duty_d = duty_q; // RL5
      bitcnt_d = bitcnt_q;
      if (bit_fall && !own_full) begin
         shadow_d = {shadow_q[FRAME_BITS-2:0], bit_val}; // RL3 RL14
         bitcnt_d = bitcnt_q + 1'b1;
      end
      if (frame_rst) begin
         bitcnt_d = '0; // RL7
         if (own_full) begin
            duty_d = shadow_q; // RL6
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         shadow_q <= '0;
         duty_q <= '0;
         bitcnt_q <= '0;
      end else begin
         shadow_q <= shadow_d;
         duty_q <= duty_d;
         bitcnt_q <= bitcnt_d;
      end
   end

   // a full buffer drops a bit; it cannot fill since output outpaces input
   fcl_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst_b(rst_b),
      .f(fwd.fifo)
   );

   // regenerator: rebuilds each forwarded bit with fixed timing
   fcl_tx_state_e tx_q, tx_d;
   logic [TX_CNT_W-1:0] txc_q, txc_d, hi_len;
   logic txb_q, txb_d, out_q, out_d;

   assign hi_len = txb_q ? TX_CNT_W'(TX_ONE_HIGH_CYC)
                         : TX_CNT_W'(TX_ZERO_HIGH_CYC);
   assign fwd.rd_ready = (tx_q == TX_IDLE);

   always_comb begin
      tx_d = tx_q;
      txc_d = txc_q + 1'b1;
      txb_d = txb_q;
      out_d = out_q;
      case (tx_q)
         TX_IDLE: begin
            txc_d = '0;
            if (fwd.rd_valid) begin
               txb_d = fwd.rd_data;
               out_d = 1'b1; // RL4
               tx_d = TX_HIGH;
            end
         end
         TX_HIGH: begin
            if (txc_q == hi_len - 1'b1) begin
               txc_d = '0;
               out_d = 1'b0;
               tx_d = TX_LOW;
            end
         end
         TX_LOW: begin
            if (txc_q == TX_CNT_W'(TX_BIT_CYC) - hi_len - 1'b1) begin
               tx_d = TX_IDLE; // RL11
            end
         end
         default: begin
            tx_d = TX_IDLE;
            out_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         tx_q <= TX_IDLE;
         txc_q <= '0;
         txb_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         tx_q <= tx_d;
         txc_q <= txc_d;
         txb_q <= txb_d;
         out_q <= out_d;
      end
   end

   // pwm compare with a per-channel phase offset
   function automatic logic pwm_on(input logic [CHAN_BITS-1:0] step,
                                   input logic [CHAN_BITS-1:0] duty,
                                   input logic [CHAN_BITS-1:0] phase);
      logic [CHAN_BITS-1:0] rel;
      rel = step - phase;
      return rel < duty;
   endfunction : pwm_on

   // pwm timebase from the local clock
   logic [PRE_W-1:0] pre_q, pre_d;
   logic [CHAN_BITS-1:0] step_q, step_d;
   logic [NUM_CHAN-1:0] pwm_q, pwm_d;
   // new duties reach channel i i cycles apart, so no frame lights all at once
   logic [NUM_CHAN-1:0] apl_q, apl_d;
   logic [NUM_CHAN-1:0][CHAN_BITS-1:0] act_q, act_d;

   always_comb begin
      pre_d = pre_q + 1'b1;
      step_d = step_q;
      act_d = act_q;
      apl_d = {apl_q[NUM_CHAN-2:0], apply}; // RL10
      if (pre_q == PRE_W'(PWM_PRESCALE - 1)) begin
         pre_d = '0; // RL16
         step_d = step_q + 1'b1; // RL9
      end
      for (int i = 0; i < NUM_CHAN; i++) begin
         if (apl_q[i]) begin
            act_d[i] = duty_q[NUM_CHAN-1-i]; // RL10
         end
         pwm_d[i] = pwm_on(step_q, act_q[i],
                           CHAN_BITS'(i * STAGGER_STEP)); // RL8 RL10
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pre_q <= '0;
         step_q <= '0;
         pwm_q <= '0;
         apl_q <= '0;
         act_q <= '0;
      end else begin
         pre_q <= pre_d;
         step_q <= step_d;
         pwm_q <= pwm_d;
         apl_q <= apl_d;
         act_q <= act_d;
      end
   end

   // outputs straight from flops
   assign cascade_serial_out = out_q;
   assign red_channel_out = pwm_q[0];
   assign green_channel_out = pwm_q[1];
   assign blue_channel_out = pwm_q[2];
   assign white_one_channel_out = pwm_q[3];
   assign white_two_channel_out = pwm_q[4];
endmodule : fcl_driver

// [design/fcl_fifo.sv]
// small synchronous fifo with valid/ready on both sides
module fcl_fifo #(
   parameter int W = 1,
   parameter int DEPTH = 4
) (
   input logic clock,
   input logic rst_b,
   fcl_fifo_if.fifo f
);
   localparam int PW = $clog2(DEPTH);

   logic [DEPTH-1:0][W-1:0] mem_q, mem_d;
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   // full and empty come straight from the occupancy count
   assign f.wr_ready = (cnt_q != (PW+1)'(DEPTH));
   assign f.rd_valid = (cnt_q != '0);
   assign f.rd_data = mem_q[rp_q];
   assign push = f.wr_valid & f.wr_ready;
   assign pop = f.rd_valid & f.rd_ready;

   // pointer and storage next values
   always_comb begin
      mem_d = mem_q;
      wp_d = wp_q;
      rp_d = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = f.wr_data;
         wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
         rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mem_q <= '0;
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         mem_q <= mem_d;
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : fcl_fifo

// [pkg/fcl_fifo_if.sv]
// handshake bundle between the receiver, the bit buffer and the regenerator
interface fcl_fifo_if #(parameter int W = 1);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;

   modport fifo (
      input wr_valid,
      input wr_data,
      input rd_ready,
      output wr_ready,
      output rd_valid,
      output rd_data
   );
   modport user (
      output wr_valid,
      output wr_data,
      output rd_ready,
      input wr_ready,
      input rd_valid,
      input rd_data
   );
endinterface : fcl_fifo_if

// [pkg/fcl_pkg.sv]
// constants shared by the five-channel led chain driver
package fcl_pkg;
   // clock rate
   localparam int CLK_MHZ = 50;
   localparam int CLK_HZ = CLK_MHZ * 1_000_000;

   // least time in ns to whole clock cycles, rounded up
   function automatic int ns_to_cyc(input int ns);
      return (ns * CLK_MHZ + 999) / 1000;
   endfunction : ns_to_cyc

   // frame layout: five bytes, msb first, red green blue white1 white2
   localparam int CHAN_BITS = 8;
   localparam int NUM_CHAN = 5;
   localparam int FRAME_BITS = CHAN_BITS * NUM_CHAN;
   localparam int BITCNT_W = 6;

   // receive timing: a zero is high 220..380 ns, a one 580..1000 ns
   localparam int ONE_SPLIT_NS = 480;
   localparam int ONE_MIN_CYC = ns_to_cyc(ONE_SPLIT_NS);
   // frame reset: line low for more than 280 us
   localparam int RESET_LOW_US = 280;
   localparam int RESET_LOW_CYC = ns_to_cyc(RESET_LOW_US * 1000) + 1;
   localparam int RUN_W = 16;

   // regenerated bit timing, 1.2 us per bit keeps pace with 800 kbit/s
   localparam int TX_ZERO_HIGH_NS = 300;
   localparam int TX_ONE_HIGH_NS = 600;
   localparam int TX_BIT_NS = 1200;
   localparam int TX_ZERO_HIGH_CYC = ns_to_cyc(TX_ZERO_HIGH_NS);
   localparam int TX_ONE_HIGH_CYC = ns_to_cyc(TX_ONE_HIGH_NS);
   localparam int TX_BIT_CYC = ns_to_cyc(TX_BIT_NS);
   localparam int TX_CNT_W = 8;

   // pwm: 256 steps, about 4 khz period
   localparam int PWM_HZ = 4000;
   localparam int PWM_STEPS = 256;
   localparam int PWM_PRESCALE = CLK_HZ / (PWM_HZ * PWM_STEPS);
   localparam int PRE_W = 8;
   localparam int STAGGER_STEP = 51;

   // forwarding buffer depth
   localparam int FIFO_DEPTH = 4;

   // regenerator states
   typedef enum logic [2:0] {
      TX_IDLE = 3'h1,
      TX_HIGH = 3'h2,
      TX_LOW = 3'h4
   } fcl_tx_state_e;
endpackage : fcl_pkg

// [verif/fcl_driver_asserts.sv]
// pin-level assertions for the five-channel led chain driver
module fcl_driver_asserts #(
   parameter int RESET_CYC = 14001,
   parameter int SILENT_CYC = 14001
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic primary_serial_in,
   input wire logic backup_serial_in,
   input wire logic cascade_serial_out,
   input wire logic red_channel_out,
   input wire logic green_channel_out,
   input wire logic blue_channel_out,
   input wire logic white_one_channel_out,
   input wire logic white_two_channel_out
);
   logic [15:0] idle_q, idle_d, chi_q, chi_d, clo_q, clo_d, rhi_q, rhi_d;
   logic app_q, app_d, seen_q, seen_d;
   logic [4:0] chan;
   assign chan = {white_two_channel_out, white_one_channel_out,
      blue_channel_out, green_channel_out, red_channel_out};
   // saturate so a long idle line cannot wrap a count
   function automatic logic [15:0] inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : v + 16'h0001;
   endfunction : inc
   // run lengths of the input line, the cascade pulse and red
   always_comb begin
      idle_d = (primary_serial_in || backup_serial_in) ? '0 : inc(idle_q);
      chi_d = cascade_serial_out ? inc(chi_q) : '0;
      clo_d = cascade_serial_out ? '0 : inc(clo_q);
      rhi_d = red_channel_out ? inc(rhi_q) : '0;
      // only a long low after real input counts as a frame reset
      seen_d = seen_q || primary_serial_in || backup_serial_in;
      app_d = app_q || (seen_q && idle_q == 16'(RESET_CYC));
   end
   // registers only
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         idle_q <= '0;
         chi_q <= '0;
         clo_q <= '0;
         rhi_q <= '0;
         app_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
         idle_q <= idle_d;
         chi_q <= chi_d;
         clo_q <= clo_d;
         rhi_q <= rhi_d;
         app_q <= app_d;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   reset_quiet_a: assert property (
      $rose(rst_b) |-> chan == 5'h00 && !cascade_serial_out)
      else $error("outputs active right after reset");
   fwd_width_a: assert property (
      $fell(cascade_serial_out) |-> chi_q == 16'd15 || chi_q == 16'd30)
      else $error("cascade pulse width is neither zero nor one");
   fwd_gap_a: assert property (
      $rose(cascade_serial_out) |-> clo_q >= 16'd30)
      else $error("cascade low time too short");
   fwd_source_a: assert property (
      $rose(cascade_serial_out) |-> idle_q < 16'd400)
      else $error("cascade pulse without recent input");
   fwd_drain_a: assert property (
      idle_q > 16'd400 |-> !cascade_serial_out)
      else $error("cascade active during long low");
   hold_dark_a: assert property (
      !app_q |-> chan == 5'h00)
      else $error("channel lit before any frame reset");
   pwm_span_a: assert property (
      rhi_q <= 16'd12240)
      else $error("red high longer than 255 steps");
   stagger_on_a: assert property (
      !($rose(red_channel_out) && $rose(green_channel_out) &&
        $rose(blue_channel_out) && $rose(white_one_channel_out) &&
        $rose(white_two_channel_out)))
      else $error("all channels turned on together");
endmodule : fcl_driver_asserts

bind fcl_driver fcl_driver_asserts #(.RESET_CYC(RESET_CYC),
   .SILENT_CYC(SILENT_CYC)) chk_u (.clock(clock), .rst_b(rst_b),
   .primary_serial_in(primary_serial_in),
   .backup_serial_in(backup_serial_in),
   .cascade_serial_out(cascade_serial_out),
   .red_channel_out(red_channel_out), .green_channel_out(green_channel_out),
   .blue_channel_out(blue_channel_out),
   .white_one_channel_out(white_one_channel_out),
   .white_two_channel_out(white_two_channel_out));

// [verif/fcl_driver_tb_top.sv]
// testbench: frames in, pwm duties and forwarded bits checked
module fcl_driver_tb_top;
   import fcl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST_CYC = 200;
   localparam int PERIOD = 12288; // 48 cycles x 256 steps
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic primary_serial_in, backup_serial_in, cascade_serial_out;
   logic [4:0] chan;
   int err_total = 0;
   int checks_done = 0;
   int hi_run = 0;
   logic exp_q[$];
   always #10 clock = ~clock;
   fcl_up_model up_u (.clock(clock), .primary_line(primary_serial_in),
      .backup_line(backup_serial_in));
   fcl_driver #(.RESET_CYC(RST_CYC), .SILENT_CYC(RST_CYC)) dut_u (
      .clock(clock), .rst_b(rst_b), .primary_serial_in(primary_serial_in),
      .backup_serial_in(backup_serial_in),
      .cascade_serial_out(cascade_serial_out), .red_channel_out(chan[0]),
      .green_channel_out(chan[1]), .blue_channel_out(chan[2]),
      .white_one_channel_out(chan[3]), .white_two_channel_out(chan[4]));
   task automatic cmp_bit(input string what, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask : cmp_bit
   task automatic cmp_cnt(input string what, input int e, input int g);
      checks_done++;
      if (g != e) begin
         err_total++;
         $display("MISMATCH %s expected %0d seen %0d", what, e, g);
      end
   endtask : cmp_cnt
   // each cascade pulse decodes by width; sampled mid-cycle to avoid races
   always @(negedge clock) begin
      if (cascade_serial_out === 1'b1) begin
         hi_run++;
      end else if (hi_run > 0) begin
         if (exp_q.size() == 0)
            cmp_bit("extra forwarded bit", 1'b0, 1'b1);
         else
            cmp_bit("forwarded bit", exp_q.pop_front(), hi_run > 22);
         hi_run = 0;
      end
   end
   // count high cycles of each channel over one whole pwm period
   task automatic measure(input logic [39:0] w);
      int hi[5];
      hi = '{default: 0};
      repeat (PERIOD) begin
         @(negedge clock);
         for (int i = 0; i < 5; i++)
            hi[i] += (chan[i] === 1'b1) ? 1 : 0;
      end
      for (int i = 0; i < 5; i++)
         cmp_cnt("channel high cycles", 48 * w[39-8*i -: 8], hi[i]);
   endtask : measure
   task automatic send_word(input logic [39:0] w, input int nbits);
      for (int i = 39; i >= 40 - nbits; i--)
         up_u.send_bit(w[i]);
   endtask : send_word
   // random bits past the first 40, noted for the monitor first
   task automatic send_extra(input int n);
      logic b;
      repeat (n) begin
         b = 1'($urandom_range(0, 1));
         exp_q.push_back(b);
         up_u.send_bit(b);
      end
   endtask : send_extra
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   // main sequence
   initial begin
      logic [39:0] wa, wb, wc;
      void'($urandom(32'hbd04425c));
      wa = {8'($urandom), $urandom};
      wb = 40'hff_00_01_80_fe;
      wc = {8'($urandom), $urandom};
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      send_word(wa, 40);
      send_extra(8);
      up_u.send_reset(RST_CYC + 40);
      measure(wa);
      $display("test frame_apply done");
      fork
         measure(wa);
         begin
            send_word(wb, 40);
            send_extra(156);
         end
      join
      $display("test hold_while_busy done");
      up_u.send_reset(RST_CYC + 40);
      measure(wb);
      $display("test next_frame done");
      send_word(wc, 20);
      up_u.send_reset(RST_CYC + 40);
      measure(wb);
      $display("test short_frame done");
      up_u.use_backup = 1'b1;
      up_u.send_bit(1'b1);
      up_u.send_reset(RST_CYC + 40);
      send_word(wc, 40);
      up_u.send_reset(RST_CYC + 40);
      measure(wc);
      $display("test backup_input done");
      cmp_cnt("bits never forwarded", 0, exp_q.size());
      summarize();
   end
   // watchdog sized well above the expected run of about 70k cycles
   initial begin
      repeat (95000) @(posedge clock);
      err_total++;
      $display("MISMATCH run length expected finish seen timeout");
      summarize();
   end
endmodule : fcl_driver_tb_top

// [verif/fcl_up_model.sv]
// upstream controller model: rz bits and long lows on either input
module fcl_up_model (
   input wire logic clock,
   output logic primary_line,
   output logic backup_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic use_backup = 1'b0;
   // rz lines idle low
   initial begin
      primary_line = 1'b0;
      backup_line = 1'b0;
   end
   // hold the selected line n cycles, changes land on falling edges
   task automatic drive(input logic lvl, input int n);
      @(negedge clock);
      if (use_backup)
         backup_line = lvl;
      else
         primary_line = lvl;
      repeat (n - 1) @(negedge clock);
   endtask : drive
   // 300/960 ns for zero, 600/660 ns for one: 1.26 us per bit
   task automatic send_bit(input logic b);
      drive(1'b1, b ? 30 : 15);
      drive(1'b0, b ? 33 : 48);
   endtask : send_bit
   // long low closes a frame
   task automatic send_reset(input int n);
      drive(1'b0, n);
   endtask : send_reset
endmodule : fcl_up_model
